/* shared/lpi_map.vh */
`ifndef LPI_MAP_VH
`define LPI_MAP_VH
// Register byte offsets
`define LPI_A_PCFG 16'h0032
`define LPI_A_MAN 16'h003A
`define LPI_A_AUTO 16'h003C
`define LPI_A_P1H 16'h0040
`define LPI_A_P1V 16'h0042
`define LPI_A_RGBH 16'h0044
`define LPI_A_RGBV 16'h0046
`define LPI_A_P2H 16'h0048
`define LPI_A_P2V 16'h004A
`define LPI_A_RGBC 16'h004C
`define LPI_A_P1SER 16'h0054
`define LPI_A_P1PAR 16'h0056
`define LPI_A_P2SER 16'h005C
`define LPI_A_P2PAR 16'h005E
`define LPI_A_STA0 16'h0210
`define LPI_A_STA1 16'h0212
// Panel configuration fields
`define LPI_F_MODE 1:0
`define LPI_F_ACT 2
`define LPI_F_BUSW 6:4
`define LPI_F_BYP 8
`define LPI_F_TFT 15:10
// Transfer control fields
`define LPI_F_GO 1
`define LPI_F_AUTO 1
// Serial and parallel setting fields
`define LPI_F_STYPE 7:5
`define LPI_F_SCS 5
`define LPI_F_SDIR 4
`define LPI_F_SFMT 3:2
`define LPI_F_CPHA 1
`define LPI_F_CPOL 0
`define LPI_F_PFMT 2:0
`define LPI_F_VSEN 7
// RGB timing fields
`define LPI_F_SIZE 9:0
`define LPI_F_ND 7:0
`define LPI_F_SW 15:8
`define LPI_F_HPOL 0
`define LPI_F_VPOL 1
`define LPI_F_DEPOL 2
`define LPI_F_CKPOL 3
`define LPI_F_HPOS 15:8
// Reset value of every register
`define LPI_R_REG 16'h0000
// Panel kinds
`define LPI_K_RGB 2'h0
`define LPI_K_PAR 2'h1
`define LPI_K_SER 2'h2
// General TFT variant code
`define LPI_TFT_GEN 6'h00
// Parallel formats
`define LPI_PF_8 3'h0
`define LPI_PF_16 3'h1
`define LPI_PF_18 3'h2
`define LPI_PF_9 3'h3
// Serial formats
`define LPI_SF_8 2'h0
`define LPI_SF_16 2'h1
`define LPI_SF_9 2'h2
// RGB bus width codes
`define LPI_BW_9 3'h0
`define LPI_BW_12 3'h1
`define LPI_BW_16 3'h2
`define LPI_BW_24 3'h3
`endif

/* src/lpi_sync.v */
`timescale 1ns/1ps
// Two-flop synchroniser for pins from outside the clock domain
module lpi_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire resetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta_q;

  // First stage feeds only the second
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* src/lpi_top.v */
`timescale 1ns/1ps
`include "lpi_map.vh"
module lpi_top (
  input wire clk_sys,
  input wire resetn,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output wire mem_req,
  output reg [18:0] mem_addr,
  input wire [15:0] mem_rdata,
  input wire cam_vsync,
  input wire p1_vsync_in,
  input wire p2_vsync_in,
  input wire host_sclk,
  input wire host_sdo,
  input wire host_cs_n,
  output wire [1:0] p1_kind,
  output wire [1:0] p2_kind,
  output wire active_panel,
  output wire [5:0] p1_tft_type,
  output wire [2:0] p1_ser_type,
  output reg [23:0] p1_data,
  output reg p1_wr_n,
  output reg p1_cs_n,
  output reg p1_dclk,
  output reg p1_hsync,
  output reg p1_vsync,
  output reg p1_de,
  output reg [17:0] p2_data,
  output reg p2_wr_n,
  output reg p2_cs_n,
  output reg p2_sclk,
  output reg p2_sdo
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_WAIT = 5'h02;
  localparam [4:0] S_FETCH = 5'h04;
  localparam [4:0] S_LATCH = 5'h08;
  localparam [4:0] S_OUT = 5'h10;

  // Panel kind of one output in a given mode
  function [1:0] kind_of;
    input [1:0] mode;
    input sec;
    begin
      case (mode)
        2'h0: kind_of = sec ? `LPI_K_SER : `LPI_K_RGB;
        2'h1: kind_of = sec ? `LPI_K_SER : `LPI_K_PAR;
        2'h2: kind_of = `LPI_K_PAR;
        default: kind_of = sec ? `LPI_K_PAR : `LPI_K_RGB;
      endcase
    end
  endfunction

  // RGB565 pixel packed onto the selected RGB bus width
  function [23:0] rgb_pack;
    input [15:0] px;
    input [2:0] bw;
    begin
      case (bw)
        `LPI_BW_9: rgb_pack = {15'h0000, px[15:13], px[10:8], px[4:2]};
        `LPI_BW_12: rgb_pack = {12'h000, px[15:12], px[10:7], px[4:1]};
        `LPI_BW_24: rgb_pack = {px[15:11], px[15:13], px[10:5],
                                px[10:9], px[4:0], px[4:2]};
        default: rgb_pack = {8'h00, px};
      endcase
    end
  endfunction

  // Parallel bus word for one beat of a pixel
  function [17:0] par_word;
    input [15:0] px;
    input [2:0] fmt;
    input beat;
    begin
      case (fmt)
        `LPI_PF_8: par_word = beat ? {10'h000, px[7:0]}
                                   : {10'h000, px[15:8]};
        `LPI_PF_9: par_word = beat ? {9'h000, px[6:0], 2'b00}
                                   : {9'h000, px[15:7]};
        `LPI_PF_18: par_word = {px[15:11], px[15], px[10:5],
                                px[4:0], px[4]};
        default: par_word = {2'b00, px};
      endcase
    end
  endfunction

  // Serial word for one beat of a pixel
  function [15:0] ser_word;
    input [15:0] px;
    input [1:0] fmt;
    input beat;
    begin
      case (fmt)
        `LPI_SF_8: ser_word = beat ? {8'h00, px[7:0]} : {8'h00, px[15:8]};
        `LPI_SF_9: ser_word = beat ? {7'h00, 1'b1, px[7:0]}
                                   : {7'h00, 1'b1, px[15:8]};
        default: ser_word = px;
      endcase
    end
  endfunction

  // Bits in one serial word
  function [4:0] ser_bits;
    input [1:0] fmt;
    begin
      case (fmt)
        `LPI_SF_16: ser_bits = 5'h10;
        `LPI_SF_9: ser_bits = 5'h09;
        default: ser_bits = 5'h08;
      endcase
    end
  endfunction

  reg [15:0] pcfg_q;
  reg [15:0] auto_q;
  reg [15:0] p1h_q;
  reg [15:0] p1v_q;
  reg [15:0] p2h_q;
  reg [15:0] p2v_q;
  reg [15:0] rgbh_q;
  reg [15:0] rgbv_q;
  reg [15:0] rgbc_q;
  reg [15:0] p1ser_q;
  reg [15:0] p1par_q;
  reg [15:0] p2ser_q;
  reg [15:0] p2par_q;
  reg [15:0] sta0_q;
  reg [15:0] sta1_q;
  reg man_q;
  reg [4:0] st_q;
  reg fm_q;
  reg [19:0] idx_q;
  reg [5:0] cyc_q;
  reg beat_q;
  reg [15:0] px_q;
  reg cam_seen_q;
  reg pvs_seen_q;
  reg [2:0] prev_q;
  reg dt_q;
  reg [10:0] hc_q;
  reg [10:0] vc_q;
  wire [5:0] s_q;

  // Camera and panel syncs, host serial pins, all from outside
  lpi_sync #(.W(6)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .din({cam_vsync, p1_vsync_in, p2_vsync_in,
          host_sclk, host_sdo, host_cs_n}),
    .dout(s_q)
  );

  // Rising edges of camera, primary and secondary VSYNC
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 3'h0;
    end else begin
      prev_q <= s_q[5:3];
    end
  end
  wire [2:0] rise = s_q[5:3] & ~prev_q;

  // Output kinds follow the mode field
  wire [1:0] mode = pcfg_q[`LPI_F_MODE];
  assign p1_kind = kind_of(mode, 1'b0);
  assign p2_kind = kind_of(mode, 1'b1);
  assign active_panel = pcfg_q[`LPI_F_ACT];
  assign p1_tft_type = pcfg_q[`LPI_F_TFT];
  // Side-channel type only meaningful with the general TFT variant
  assign p1_ser_type = (p1_tft_type == `LPI_TFT_GEN)
                       ? p1ser_q[`LPI_F_STYPE] : 3'h0;

  wire act = active_panel;
  wire [1:0] kact = act ? p2_kind : p1_kind;
  wire rgb_on = !act && (p1_kind == `LPI_K_RGB);
  wire ser = (kact == `LPI_K_SER);
  // Settings of whichever output is active
  wire [15:0] parx = act ? p2par_q : p1par_q;
  wire [9:0] hs = act ? p2h_q[`LPI_F_SIZE] : p1h_q[`LPI_F_SIZE];
  wire [9:0] vs = act ? p2v_q[`LPI_F_SIZE] : p1v_q[`LPI_F_SIZE];
  wire [19:0] total = hs * vs;
  wire vs_en = parx[`LPI_F_VSEN];
  wire pvs_rise = act ? rise[0] : rise[1];
  wire [2:0] pfmt = parx[`LPI_F_PFMT];
  wire [1:0] sfmt = p2ser_q[`LPI_F_SFMT];
  wire [4:0] nbit = ser_bits(sfmt);
  wire two = ser ? (sfmt != `LPI_SF_16)
                 : (pfmt == `LPI_PF_8 || pfmt == `LPI_PF_9);
  wire [5:0] cyc_end = ser ? ({nbit, 1'b0} - 6'h01) : 6'h01;
  wire [18:0] sta = {sta1_q[2:0], sta0_q};
  wire byp = pcfg_q[`LPI_F_BYP];

  // Trigger decisions, only consulted while idle
  wire go_man = man_q;
  wire go_auto = auto_q[`LPI_F_AUTO] && cam_seen_q
                 && (!vs_en || pvs_seen_q);
  wire idle = st_q[0];
  wire eng_start = idle && !rgb_on && (go_man || go_auto);
  wire eng_next = st_q[4] && (cyc_q == cyc_end) && (!two || beat_q);
  wire last = (idx_q + 20'h00001) >= total;
  wire eng_done = eng_next && last;

  // Register writes; the manual trigger register is handled separately
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pcfg_q <= `LPI_R_REG;
      auto_q <= `LPI_R_REG;
      p1h_q <= `LPI_R_REG;
      p1v_q <= `LPI_R_REG;
      p2h_q <= `LPI_R_REG;
      p2v_q <= `LPI_R_REG;
      rgbh_q <= `LPI_R_REG;
      rgbv_q <= `LPI_R_REG;
      rgbc_q <= `LPI_R_REG;
      p1ser_q <= `LPI_R_REG;
      p1par_q <= `LPI_R_REG;
      p2ser_q <= `LPI_R_REG;
      p2par_q <= `LPI_R_REG;
      sta0_q <= `LPI_R_REG;
      sta1_q <= `LPI_R_REG;
    end else if (reg_wr) begin
      case (reg_addr)
        `LPI_A_PCFG: pcfg_q <= reg_wdata;
        `LPI_A_AUTO: auto_q <= reg_wdata;
        `LPI_A_P1H: p1h_q <= reg_wdata;
        `LPI_A_P1V: p1v_q <= reg_wdata;
        `LPI_A_P2H: p2h_q <= reg_wdata;
        `LPI_A_P2V: p2v_q <= reg_wdata;
        `LPI_A_RGBH: rgbh_q <= reg_wdata;
        `LPI_A_RGBV: rgbv_q <= reg_wdata;
        `LPI_A_RGBC: rgbc_q <= reg_wdata;
        `LPI_A_P1SER: p1ser_q <= reg_wdata;
        `LPI_A_P1PAR: p1par_q <= reg_wdata;
        `LPI_A_P2SER: p2ser_q <= reg_wdata;
        `LPI_A_P2PAR: p2par_q <= reg_wdata;
        `LPI_A_STA0: sta0_q <= reg_wdata;
        `LPI_A_STA1: sta1_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Manual trigger: writes while busy are dropped, set beats clear
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      man_q <= 1'b0;
    end else if (reg_wr && reg_addr == `LPI_A_MAN && idle
                 && reg_wdata[`LPI_F_GO]) begin
      man_q <= 1'b1;
    end else if (eng_done && fm_q) begin
      man_q <= 1'b0;
    end
  end

  // Read data is registered; unmapped offsets read zero
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `LPI_A_PCFG: reg_rdata <= pcfg_q;
        `LPI_A_MAN: reg_rdata <= {!idle, 13'h0000, man_q, 1'b0};
        `LPI_A_AUTO: reg_rdata <= auto_q;
        `LPI_A_P1H: reg_rdata <= p1h_q;
        `LPI_A_P1V: reg_rdata <= p1v_q;
        `LPI_A_P2H: reg_rdata <= p2h_q;
        `LPI_A_P2V: reg_rdata <= p2v_q;
        `LPI_A_RGBH: reg_rdata <= rgbh_q;
        `LPI_A_RGBV: reg_rdata <= rgbv_q;
        `LPI_A_RGBC: reg_rdata <= rgbc_q;
        `LPI_A_P1SER: reg_rdata <= p1ser_q;
        `LPI_A_P1PAR: reg_rdata <= p1par_q;
        `LPI_A_P2SER: reg_rdata <= p2ser_q;
        `LPI_A_P2PAR: reg_rdata <= p2par_q;
        `LPI_A_STA0: reg_rdata <= sta0_q;
        `LPI_A_STA1: reg_rdata <= sta1_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Sync capture: only while idle, so events during a frame are lost
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cam_seen_q <= 1'b0;
      pvs_seen_q <= 1'b0;
    end else if (!auto_q[`LPI_F_AUTO] || eng_start) begin
      cam_seen_q <= 1'b0;
      pvs_seen_q <= 1'b0;
    end else if (idle) begin
      if (rise[2]) cam_seen_q <= 1'b1;
      if (pvs_rise) pvs_seen_q <= 1'b1;
    end
  end

  // Frame transfer engine for RAM-integrated panels
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      fm_q <= 1'b0;
      idx_q <= 20'h00000;
      cyc_q <= 6'h00;
      beat_q <= 1'b0;
      px_q <= 16'h0000;
    end else if (rgb_on) begin
      st_q <= S_IDLE;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (eng_start) begin
            fm_q <= go_man;
            idx_q <= 20'h00000;
            st_q <= (go_man && vs_en) ? S_WAIT : S_FETCH;
          end
        end
        S_WAIT: begin
          if (pvs_rise) st_q <= S_FETCH;
        end
        S_FETCH: st_q <= S_LATCH;
        S_LATCH: begin
          px_q <= mem_rdata;
          cyc_q <= 6'h00;
          beat_q <= 1'b0;
          st_q <= S_OUT;
        end
        S_OUT: begin
          if (cyc_q != cyc_end) begin
            cyc_q <= cyc_q + 6'h01;
          end else if (two && !beat_q) begin
            cyc_q <= 6'h00;
            beat_q <= 1'b1;
          end else if (last) begin
            st_q <= S_IDLE;
          end else begin
            idx_q <= idx_q + 20'h00001;
            st_q <= S_FETCH;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // RGB timing: one pixel every two system clocks
  wire [10:0] htot = {1'b0, p1h_q[`LPI_F_SIZE]}
                     + {3'h0, rgbh_q[`LPI_F_ND]};
  wire [10:0] vtot = {1'b0, p1v_q[`LPI_F_SIZE]}
                     + {3'h0, rgbv_q[`LPI_F_ND]};
  wire h_end = (hc_q + 11'h001) >= htot;
  wire v_end = (vc_q + 11'h001) >= vtot;
  wire in_act = (hc_q < {1'b0, p1h_q[`LPI_F_SIZE]})
                && (vc_q < {1'b0, p1v_q[`LPI_F_SIZE]});
  wire [10:0] hs0 = {1'b0, p1h_q[`LPI_F_SIZE]} + {3'h0, rgbc_q[`LPI_F_HPOS]};
  wire [10:0] hs1 = hs0 + {3'h0, rgbh_q[`LPI_F_SW]};
  wire [10:0] vs0 = {1'b0, p1v_q[`LPI_F_SIZE]};
  wire [10:0] vs1 = vs0 + {3'h0, rgbv_q[`LPI_F_SW]};
  wire in_hs = (hc_q >= hs0) && (hc_q < hs1);
  wire in_vs = (vc_q >= vs0) && (vc_q < vs1);
  wire rgb_fetch = rgb_on && !dt_q && in_act;
  wire rgb_sof = rgb_on && dt_q && h_end && v_end;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dt_q <= 1'b0;
      hc_q <= 11'h000;
      vc_q <= 11'h000;
    end else if (!rgb_on) begin
      dt_q <= 1'b0;
      hc_q <= 11'h000;
      vc_q <= 11'h000;
    end else begin
      dt_q <= !dt_q;
      if (dt_q) begin
        hc_q <= h_end ? 11'h000 : hc_q + 11'h001;
        if (h_end) vc_q <= v_end ? 11'h000 : vc_q + 11'h001;
      end
    end
  end

  // Fetch pointer restarts at the window start for every frame
  assign mem_req = rgb_fetch || st_q[2];
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_addr <= 19'h00000;
    end else if ((idle && !rgb_on) || rgb_sof) begin
      mem_addr <= sta;
    end else if (rgb_fetch || (eng_next && !last)) begin
      mem_addr <= mem_addr + 19'h00002;
    end
  end

  // Primary pins: RGB timing or parallel writes, never serial
  wire busy = st_q[2] || st_q[3] || st_q[4];
  wire p1_own = !act && (p1_kind == `LPI_K_PAR);
  wire p2_own = act;
  wire [17:0] pw = par_word(px_q, pfmt, beat_q);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      p1_data <= 24'h000000;
      p1_wr_n <= 1'b1;
      p1_cs_n <= 1'b1;
      p1_dclk <= 1'b0;
      p1_hsync <= 1'b0;
      p1_vsync <= 1'b0;
      p1_de <= 1'b0;
    end else begin
      p1_cs_n <= !(p1_own && busy);
      p1_wr_n <= !(p1_own && st_q[4] && cyc_q == 6'h00);
      p1_dclk <= rgbc_q[`LPI_F_CKPOL] ^ (rgb_on && dt_q);
      p1_hsync <= rgbc_q[`LPI_F_HPOL] ^ (rgb_on && in_hs);
      p1_vsync <= rgbc_q[`LPI_F_VPOL] ^ (rgb_on && in_vs);
      if (rgb_on && dt_q) begin
        p1_de <= rgbc_q[`LPI_F_DEPOL] ^ in_act;
        if (in_act)
          p1_data <= rgb_pack(mem_rdata, pcfg_q[`LPI_F_BUSW]);
      end else if (!rgb_on) begin
        p1_de <= rgbc_q[`LPI_F_DEPOL];
        if (p1_own && st_q[4]) p1_data <= {6'h00, pw};
      end
    end
  end

  // Secondary pins: parallel writes, serial shifter or host bypass
  wire [15:0] sw = ser_word(px_q, sfmt, beat_q);
  wire [4:0] bi = cyc_q[5:1];
  wire [4:0] bsel = p2ser_q[`LPI_F_SDIR] ? bi : nbit - 5'h01 - bi;
  wire frame_cs = p2ser_q[`LPI_F_SCS];
  wire cpol = p2ser_q[`LPI_F_CPOL];
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      p2_data <= 18'h00000;
      p2_wr_n <= 1'b1;
      p2_cs_n <= 1'b1;
      p2_sclk <= 1'b0;
      p2_sdo <= 1'b0;
    end else if (byp && p2_kind == `LPI_K_SER) begin
      p2_cs_n <= s_q[0];
      p2_sdo <= s_q[1];
      p2_sclk <= s_q[2];
      p2_wr_n <= 1'b1;
    end else if (ser) begin
      p2_wr_n <= 1'b1;
      p2_cs_n <= !(frame_cs ? busy : st_q[4]);
      if (st_q[4]) begin
        p2_sdo <= sw[bsel[3:0]];
        p2_sclk <= cpol ^ cyc_q[0] ^ p2ser_q[`LPI_F_CPHA];
      end else begin
        p2_sclk <= cpol;
      end
    end else begin
      p2_sclk <= cpol;
      p2_cs_n <= !(p2_own && busy);
      p2_wr_n <= !(p2_own && st_q[4] && cyc_q == 6'h00);
      if (p2_own && st_q[4]) p2_data <= pw;
    end
  end
endmodule

/* tb/lpi_assertions.sv */
`timescale 1ns/1ps
`include "lpi_map.vh"
// Port checker; shadows of written setup give the expected kinds
module lpi_assertions (
  input wire clk_sys,
  input wire resetn,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire mem_req,
  input wire host_sclk,
  input wire [1:0] p1_kind,
  input wire [1:0] p2_kind,
  input wire active_panel,
  input wire [5:0] p1_tft_type,
  input wire [2:0] p1_ser_type,
  input wire p1_wr_n,
  input wire p1_cs_n,
  input wire p2_wr_n,
  input wire p2_cs_n,
  input wire p2_sclk
);
  reg [15:0] cfg_q;
  reg [15:0] ser_q;
  wire [1:0] m = cfg_q[`LPI_F_MODE];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Shadows update on the same edge as the block's own registers
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= `LPI_R_REG;
      ser_q <= `LPI_R_REG;
    end else if (reg_wr) begin
      if (reg_addr == `LPI_A_PCFG) cfg_q <= reg_wdata;
      if (reg_addr == `LPI_A_P1SER) ser_q <= reg_wdata;
    end
  end
  chk_p1_kind_mode: assert property (
    p1_kind == ((m == 2'h0 || m == 2'h3) ? `LPI_K_RGB : `LPI_K_PAR))
    else $error("primary kind wrong");
  chk_p2_kind_mode: assert property (
    p2_kind == (m[1] ? `LPI_K_PAR : `LPI_K_SER))
    else $error("secondary kind wrong");
  chk_active_one: assert property (
    active_panel == cfg_q[`LPI_F_ACT]) else $error("active panel wrong");
  chk_tft_variant: assert property (
    p1_tft_type == cfg_q[`LPI_F_TFT]) else $error("tft variant wrong");
  chk_ser_type: assert property (
    p1_ser_type == ((cfg_q[`LPI_F_TFT] == `LPI_TFT_GEN) ?
    ser_q[`LPI_F_STYPE] : 3'h0)) else $error("side serial type wrong");
  chk_unmapped_zero: assert property (
    reg_rd && !(reg_addr inside {[16'h0032:16'h005E], 16'h0210,
    16'h0212}) |=> reg_rdata == 16'h0000) else $error("unmapped read");
  chk_fetch_pulse: assert property (
    mem_req |=> !mem_req) else $error("fetch request held");
  chk_wr_pulse: assert property (
    !p1_wr_n |=> p1_wr_n) else $error("write strobe held");
  chk_wr_in_select: assert property (
    !p2_wr_n |-> !p2_cs_n) else $error("strobe outside select");
  chk_p1_wr_select: assert property (
    !p1_wr_n |-> !p1_cs_n) else $error("primary strobe outside select");
  chk_bypass_follow: assert property (
    (cfg_q[`LPI_F_BYP] && p2_kind == `LPI_K_SER && $stable(host_sclk))[*5]
    |-> p2_sclk == host_sclk) else $error("bypass clock wrong");
endmodule
bind lpi_top lpi_assertions u_lpi_assertions (.clk_sys(clk_sys),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mem_req(mem_req), .host_sclk(host_sclk), .p1_kind(p1_kind),
  .p2_kind(p2_kind), .active_panel(active_panel),
  .p1_tft_type(p1_tft_type), .p1_ser_type(p1_ser_type),
  .p1_wr_n(p1_wr_n), .p1_cs_n(p1_cs_n), .p2_wr_n(p2_wr_n),
  .p2_cs_n(p2_cs_n), .p2_sclk(p2_sclk));

/* tb/lpi_panel_model.sv */
`timescale 1ns/1ps
// Image memory and panel sync source on the far side
module lpi_panel_model (
  input wire clk_sys,
  input wire mem_req,
  input wire [18:0] mem_addr,
  output reg [15:0] mem_rdata,
  input wire vs_kick,
  output reg p1_vsync_in,
  output reg p2_vsync_in
);
  reg [2:0] vs_cnt_q = 3'h0;
  initial mem_rdata = 16'h0000;
  // One cycle answer; scrambled otherwise so stale data cannot pass
  always @(posedge clk_sys) begin
    if (mem_req) mem_rdata <= mem_addr[15:0] ^ 16'h5A3C;
    else mem_rdata <= ~mem_rdata;
  end
  // Panel VSYNC pulse of four cycles on both outputs
  always @(posedge clk_sys) begin
    if (vs_kick) vs_cnt_q <= 3'h4;
    else if (vs_cnt_q != 3'h0) vs_cnt_q <= vs_cnt_q - 3'h1;
  end
  always @* begin
    p1_vsync_in = (vs_cnt_q != 3'h0);
    p2_vsync_in = (vs_cnt_q != 3'h0);
  end
endmodule

/* tb/lcd_panel_interface_control_test.sv */
`timescale 1ns/1ps
`include "lpi_map.vh"
`define CHK(g, e) begin logic [63:0] cg_v, ce_v; cg_v = 64'(g); \
  ce_v = 64'(e); check_count++; if (cg_v !== ce_v) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cg_v, ce_v); end end
module lcd_panel_interface_control_test;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg cam_vsync = 1'b0;
  reg vs_kick = 1'b0;
  reg host_sclk = 1'b0;
  reg host_sdo = 1'b0;
  reg host_cs_n = 1'b1;
  reg rd_d = 1'b0;
  reg ser_on = 1'b0;
  reg sck_d = 1'b0;
  reg cs_d = 1'b1;
  reg [15:0] sh = 16'h0000;
  wire [15:0] reg_rdata, mem_rdata;
  wire [18:0] mem_addr;
  wire mem_req, p1_vsync_in, p2_vsync_in, active_panel;
  wire [1:0] p1_kind, p2_kind;
  wire [5:0] p1_tft_type;
  wire [2:0] p1_ser_type;
  wire [23:0] p1_data;
  wire [17:0] p2_data;
  wire p1_wr_n, p1_cs_n, p1_dclk, p1_hsync, p1_vsync, p1_de;
  wire p2_wr_n, p2_cs_n, p2_sclk, p2_sdo;
  integer err_count = 0;
  integer check_count = 0;
  logic [15:0] rd_q[$];
  logic [15:0] px_q[$];
  logic [18:0] ad_q[$];
  logic [1:0] k1 [4] = '{`LPI_K_RGB, `LPI_K_PAR, `LPI_K_PAR, `LPI_K_RGB};
  logic [1:0] k2 [4] = '{`LPI_K_SER, `LPI_K_SER, `LPI_K_PAR, `LPI_K_PAR};
  logic [15:0] regs [7] = '{`LPI_A_PCFG, `LPI_A_MAN, `LPI_A_AUTO,
    `LPI_A_P1SER, `LPI_A_P1PAR, `LPI_A_P2SER, `LPI_A_P2PAR};
  always #5 clk_sys = ~clk_sys;
  lpi_top u_lpi_top (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .cam_vsync(cam_vsync),
    .p1_vsync_in(p1_vsync_in), .p2_vsync_in(p2_vsync_in),
    .host_sclk(host_sclk), .host_sdo(host_sdo), .host_cs_n(host_cs_n),
    .p1_kind(p1_kind), .p2_kind(p2_kind), .active_panel(active_panel),
    .p1_tft_type(p1_tft_type), .p1_ser_type(p1_ser_type),
    .p1_data(p1_data), .p1_wr_n(p1_wr_n), .p1_cs_n(p1_cs_n),
    .p1_dclk(p1_dclk), .p1_hsync(p1_hsync), .p1_vsync(p1_vsync),
    .p1_de(p1_de), .p2_data(p2_data), .p2_wr_n(p2_wr_n),
    .p2_cs_n(p2_cs_n), .p2_sclk(p2_sclk), .p2_sdo(p2_sdo));
  lpi_panel_model u_lpi_panel_model (.clk_sys(clk_sys), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .vs_kick(vs_kick),
    .p1_vsync_in(p1_vsync_in), .p2_vsync_in(p2_vsync_in));
  // An empty queue yields unknown, so any surplus result fails
  function automatic logic [15:0] nx_px();
    return px_q.size() ? px_q.pop_front() : 'x;
  endfunction
  function automatic logic [18:0] nx_ad();
    return ad_q.size() ? ad_q.pop_front() : 'x;
  endfunction
  // Each result is matched against the oldest note
  always @(posedge clk_sys) begin
    if (rd_d) `CHK(reg_rdata, rd_q.pop_front())
    rd_d <= reg_rd;
    if (mem_req === 1'b1 && p1_kind === `LPI_K_PAR)
      `CHK(mem_addr, nx_ad())
    if (p1_wr_n === 1'b0 && p1_kind === `LPI_K_PAR)
      `CHK(p1_data[15:0], nx_px())
    if (p2_wr_n === 1'b0 && p2_kind === `LPI_K_PAR)
      `CHK(p2_data[15:0], nx_px())
    // Serial words: shift on each rising clock, compare when select lifts
    sck_d <= p2_sclk;
    cs_d <= p2_cs_n;
    if (ser_on && p2_cs_n === 1'b0 && p2_sclk === 1'b1 && !sck_d)
      sh <= {sh[14:0], p2_sdo};
    if (ser_on && p2_cs_n === 1'b1 && cs_d === 1'b0)
      `CHK(sh, nx_px())
  end
  task automatic wr(input [15:0] a, input [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input [15:0] a, input [15:0] e);
    rd_q.push_back(e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask
  task automatic expect_frame(input int n, input [18:0] s);
    for (int i = 0; i < n; i++) begin
      ad_q.push_back(s + 19'(2 * i));
      px_q.push_back(16'(s + 19'(2 * i)) ^ 16'h5A3C);
    end
  endtask
  task automatic pulse(input int cam);
    @(negedge clk_sys);
    if (cam) cam_vsync = 1'b1;
    else vs_kick = 1'b1;
    repeat (4) @(negedge clk_sys);
    cam_vsync = 1'b0;
    vs_kick = 1'b0;
  endtask
  // Bounded wait; the tail catches a frame that runs too long
  task automatic drain();
    int t;
    t = 0;
    while (px_q.size() != 0 && t < 400) begin
      @(negedge clk_sys);
      t++;
    end
    repeat (12) @(negedge clk_sys);
    `CHK(px_q.size(), 0)
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] v, w;
    logic [18:0] s;
    void'($urandom(32'h0C21));
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    // Reset values, then an unmapped place that must stay empty
    foreach (regs[i]) rd(regs[i], `LPI_R_REG);
    wr(16'h0030, 16'hFFFF);
    rd(16'h0030, 16'h0000);
    // Every mode, with the general variant on even passes
    for (int m = 0; m < 4; m++) begin
      w = 16'($urandom);
      v = 16'($urandom) & 16'hFEFC | 16'(m);
      if (m % 2 == 0) v[15:10] = `LPI_TFT_GEN;
      wr(`LPI_A_P1SER, w);
      wr(`LPI_A_PCFG, v);
      `CHK(p1_kind, k1[m])
      `CHK(p2_kind, k2[m])
      `CHK(active_panel, v[2])
      `CHK(p1_tft_type, v[15:10])
      `CHK(p1_ser_type, v[15:10] == 6'h00 ? w[7:5] : 3'h0)
    end
    // Manual frame on the primary parallel panel; the second trigger comes while busy and is dropped
    wr(`LPI_A_PCFG, 16'h0001);
    wr(`LPI_A_P1H, 16'h0002);
    wr(`LPI_A_P1V, 16'h0001);
    wr(`LPI_A_P1PAR, {13'h0, `LPI_PF_16});
    s = 19'($urandom) & 19'h7FFFE;
    wr(`LPI_A_STA0, s[15:0]);
    wr(`LPI_A_STA1, {13'h0, s[18:16]});
    expect_frame(2, s);
    wr(`LPI_A_MAN, 16'h0002);
    wr(`LPI_A_MAN, 16'h0002);
    drain();
    rd(`LPI_A_MAN, 16'h0000);
    // Held until the panel VSYNC: nothing noted while waiting
    wr(`LPI_A_P1PAR, 16'h0081);
    wr(`LPI_A_MAN, 16'h0002);
    repeat (20) @(negedge clk_sys);
    expect_frame(2, s);
    pulse(0);
    drain();
    // Automatic: camera sync alone is not enough with VSYNC input on
    wr(`LPI_A_AUTO, 16'h0002);
    pulse(1);
    repeat (20) @(negedge clk_sys);
    expect_frame(2, s);
    pulse(0);
    drain();
    wr(`LPI_A_P1PAR, {13'h0, `LPI_PF_16});
    expect_frame(2, s);
    pulse(1);
    drain();
    wr(`LPI_A_AUTO, 16'h0000);
    // Secondary active: own sizes and own format register
    wr(`LPI_A_PCFG, 16'h0006);
    wr(`LPI_A_P1PAR, {13'h0, `LPI_PF_18});
    wr(`LPI_A_P2PAR, {13'h0, `LPI_PF_16});
    wr(`LPI_A_P2H, 16'h0001);
    wr(`LPI_A_P2V, 16'h0003);
    s = 19'($urandom) & 19'h7FFFE;
    wr(`LPI_A_STA0, s[15:0]);
    wr(`LPI_A_STA1, {13'h0, s[18:16]});
    expect_frame(3, s);
    wr(`LPI_A_MAN, 16'h0002);
    drain();
    // Secondary serial: 16-bit words, MSB first, select per word
    wr(`LPI_A_PCFG, 16'h0005);
    wr(`LPI_A_P2SER, {12'h000, `LPI_SF_16, 2'b00});
    wr(`LPI_A_P2H, 16'h0002);
    wr(`LPI_A_P2V, 16'h0001);
    ser_on = 1'b1;
    expect_frame(2, s);
    wr(`LPI_A_MAN, 16'h0002);
    drain();
    ser_on = 1'b0;
    // Bypass: host serial clock at 80 ns within one select frame
    wr(`LPI_A_PCFG, 16'h0100);
    host_cs_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      host_sclk = ~host_sclk;
      host_sdo = 1'($urandom);
      repeat (4) @(negedge clk_sys);
      `CHK({p2_sclk, p2_sdo, p2_cs_n}, {host_sclk, host_sdo, 1'b0})
    end
    host_cs_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK(p2_cs_n, 1'b1)
    tally_and_finish();
  end
endmodule
